// *** shared/cbu_pkg.sv ***
package cbu_pkg;
  // ****************************************
  // instruction field layout
  // ****************************************
  localparam int CBU_OPC_MSB = 31;
  localparam int CBU_OPC_LSB = 26;
  localparam int CBU_RS_MSB = 25;
  localparam int CBU_RS_LSB = 21;
  localparam int CBU_RT_MSB = 20;
  localparam int CBU_RT_LSB = 16;
  localparam int CBU_OFS_MSB = 15;
  localparam int CBU_OFS_LSB = 0;
  localparam int CBU_OFS_SHIFT = 2;
  localparam int CBU_OFS_EXT_W = 18;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [5:0] CBU_OPC_BR_EQ = 6'h04;
  localparam logic [5:0] CBU_OPC_BR_EQ_LIKELY = 6'h14;
  localparam logic [5:0] CBU_OPC_REG_IMM_CLASS = 6'h01;
  localparam logic [4:0] CBU_RT_BR_NONNEG = 5'h01;
  localparam logic [4:0] CBU_RT_BR_NONNEG_LINK = 5'h11;
  localparam logic [4:0] CBU_RT_BR_NONNEG_LINK_LIKELY = 5'h13;
  localparam logic [4:0] CBU_RT_BR_NONNEG_LIKELY = 5'h03;
  localparam logic [4:0] CBU_LINK_REG = 5'h1f;
  localparam logic [31:0] CBU_LINK_OFFSET = 32'h0000_0008;
  localparam logic [31:0] CBU_SLOT_OFFSET = 32'h0000_0004;
  localparam logic [31:0] CBU_PC_RESET = 32'h0000_0000;
  // ****************************************
  // slot tracking states
  // ****************************************
  typedef enum logic [0:0] {CBU_IDLE, CBU_SLOT} cbu_state_t;
endpackage

// *** rtl/cbu_decode.sv ***
`timescale 1ns/100ps
// combinational classifier for one fetched instruction
module cbu_decode
  import cbu_pkg::*;
(
  input wire logic [31:0] instr,
  input wire logic [31:0] rs_value,
  input wire logic [31:0] rt_value,
  output logic is_branch,
  output logic is_likely,
  output logic is_link,
  output logic cond_true,
  output logic [31:0] target_offset
);
  logic [5:0] opc;
  logic [4:0] rtf;
  logic [CBU_OFS_EXT_W-1:0] ofs_shifted;
  assign opc = instr[CBU_OPC_MSB:CBU_OPC_LSB];
  assign rtf = instr[CBU_RT_MSB:CBU_RT_LSB];
  // offset times four, then sign extended to the word
  assign ofs_shifted = {instr[CBU_OFS_MSB:CBU_OFS_LSB], {CBU_OFS_SHIFT{1'b0}}}; // RULE1
  assign target_offset = {{(32 - CBU_OFS_EXT_W){ofs_shifted[CBU_OFS_EXT_W-1]}}, ofs_shifted}; // RULE1
  // class decode; the likely non-negative plain form is decoded but its encoding is not relied on
  always_comb begin
    is_branch = 1'b0;
    is_likely = 1'b0;
    is_link = 1'b0;
    cond_true = 1'b0;
    if (opc == CBU_OPC_BR_EQ || opc == CBU_OPC_BR_EQ_LIKELY) begin
      is_branch = 1'b1;
      is_likely = (opc == CBU_OPC_BR_EQ_LIKELY); // RULE3
      // two zero-register sources read equal, so the alias always branches
      cond_true = (rs_value == rt_value); // RULE2 RULE9
    end else if (opc == CBU_OPC_REG_IMM_CLASS) begin
      // zero register source has sign bit clear, so the call alias always links and branches
      cond_true = ~rs_value[31]; // RULE5 RULE10
      unique case (rtf)
        CBU_RT_BR_NONNEG: is_branch = 1'b1;
        CBU_RT_BR_NONNEG_LIKELY: begin
          is_branch = 1'b1;
          is_likely = 1'b1;
        end
        CBU_RT_BR_NONNEG_LINK: begin
          is_branch = 1'b1;
          is_link = 1'b1; // RULE6
        end
        CBU_RT_BR_NONNEG_LINK_LIKELY: begin
          is_branch = 1'b1;
          is_likely = 1'b1;
          is_link = 1'b1; // RULE7
        end
        default: is_branch = 1'b0;
      endcase
    end
  end
endmodule

// *** rtl/cbu_top.sv ***
`timescale 1ns/100ps
// Summary of operation
// RULE1: target is sign-extended offset times four plus delay-slot address
// RULE2: equal compare branches to target after the delay slot runs
// RULE3: equal-likely branches to target after slot when registers match
// RULE4: likely forms cancel the delay slot when the condition is false
// RULE5: non-negative test is true when source sign bit is clear
// RULE6: link forms write register 31 with branch address plus 8, always
// RULE7: link-likely combines the link write with slot cancel on false
// RULE8: condition and link in branch cycle; program counter moves at slot
// RULE9: equal compare of zero register with itself always branches
// RULE10: non-negative link on zero register always branches and links
// RULE11: software keeps branches, jumps, returns and wait out of slots
// RULE12: software never names register 31 as source of a link form
// RULE13: an exception in the slot restarts from the branch address
// RULE14: software should use likely forms only for nearly always-taken branches
module cbu_top
  import cbu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] rs_value,
  input wire logic [31:0] rt_value,
  input wire logic slot_exception,
  output logic [4:0] rs_index,
  output logic [4:0] rt_index,
  output logic link_we,
  output logic [4:0] link_index,
  output logic [31:0] link_value,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic slot_nullify,
  output logic in_delay_slot,
  output logic [31:0] restart_pc
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_sync_q;
  // two stage release so deassertion is clean on clk_sys
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  logic is_branch;
  logic is_likely;
  logic is_link;
  logic cond_true;
  logic [31:0] target_offset;
  logic take_branch;
  // register file read indices straight from the instruction
  assign rs_index = instr[CBU_RS_MSB:CBU_RS_LSB];
  assign rt_index = instr[CBU_RT_MSB:CBU_RT_LSB];

  cbu_decode u_decode (
    .instr(instr),
    .rs_value(rs_value),
    .rt_value(rt_value),
    .is_branch(is_branch),
    .is_likely(is_likely),
    .is_link(is_link),
    .cond_true(cond_true),
    .target_offset(target_offset)
  );

  cbu_state_t state_q;
  logic cond_q;
  logic likely_q;
  logic [31:0] target_q;
  logic [31:0] branch_pc_q;
  // a branch seen while in a slot is ignored; software keeps it out
  assign take_branch = instr_valid && is_branch && (state_q == CBU_IDLE); // RULE11

  // ****************************************
  // branch cycle capture
  // ****************************************
  // condition and target frozen in the branch's own cycle
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cond_q <= 1'b0;
      likely_q <= 1'b0;
      target_q <= CBU_PC_RESET;
      branch_pc_q <= CBU_PC_RESET;
    end else if (take_branch) begin
      cond_q <= cond_true; // RULE8
      likely_q <= is_likely;
      // base is the slot address, not the branch
      target_q <= instr_pc + CBU_SLOT_OFFSET + target_offset; // RULE1
      branch_pc_q <= instr_pc; // RULE13
    end
  end

  // slot tracking: waits for the next valid instruction or a slot exception
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= CBU_IDLE;
    end else begin
      unique case (state_q)
        CBU_IDLE: if (take_branch) state_q <= CBU_SLOT;
        CBU_SLOT: if (instr_valid || slot_exception) state_q <= CBU_IDLE;
      endcase
    end
  end

  // ****************************************
  // link write
  // ****************************************
  // written whether or not taken; source 31 would be clobbered, so software avoids it
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      link_we <= 1'b0;
      link_index <= 5'h00;
      link_value <= CBU_PC_RESET;
    end else begin
      link_we <= take_branch && is_link; // RULE6 RULE7 RULE12
      if (take_branch && is_link) begin
        link_index <= CBU_LINK_REG; // RULE6
        link_value <= instr_pc + CBU_LINK_OFFSET; // RULE6 RULE8
      end
    end
  end

  // ****************************************
  // slot outcome
  // ****************************************
  logic slot_now;
  assign slot_now = (state_q == CBU_SLOT) && instr_valid && !slot_exception;
  // handshake outputs follow the slot instruction combinationally
  assign redirect_valid = slot_now && cond_q; // RULE2 RULE3 RULE5 RULE8
  assign redirect_pc = target_q;
  assign slot_nullify = slot_now && likely_q && !cond_q; // RULE4 RULE7
  assign in_delay_slot = (state_q == CBU_SLOT);
  // on a slot exception the handler resumes at the branch itself
  assign restart_pc = branch_pc_q; // RULE13
endmodule

// *** testbench/cbu_top_assertions.sv ***
`timescale 1ns/100ps
module cbu_top_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] instr_pc,
  input wire logic slot_exception,
  input wire logic link_we,
  input wire logic [4:0] link_index,
  input wire logic [31:0] link_value,
  input wire logic redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic slot_nullify,
  input wire logic in_delay_slot,
  input wire logic [31:0] restart_pc
);
  // branch accepted only outside a slot
  wire logic [4:0] rt = instr[20:16];
  wire logic ri = instr[31:26] == 6'h01 && (rt == 5'h01 || rt == 5'h03 || rt == 5'h11 || rt == 5'h13);
  wire logic br = instr_valid && !in_delay_slot && (instr[31:26] == 6'h04 || instr[31:26] == 6'h14 || ri);
  wire logic lk = br && ri && rt[4];
  wire logic [31:0] tg = instr_pc + 32'h4 + {{14{instr[15]}}, instr[15:0], 2'b00};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_link_index: assert property (link_we |-> link_index == 5'h1f) else $error("bad link index");
  a_link_value: assert property (lk |=> link_we && link_value == $past(instr_pc) + 32'h8) else $error("bad link");
  a_link_cause: assert property (link_we |-> $past(lk)) else $error("stray link write");
  a_slot_enter: assert property (br |=> in_delay_slot && restart_pc == $past(instr_pc)) else $error("bad slot");
  a_target_pc: assert property (br |=> redirect_pc == $past(tg)) else $error("bad target");
  a_redir_slot: assert property (redirect_valid |-> in_delay_slot && instr_valid && !slot_exception)
    else $error("redirect outside slot");
  a_null_slot: assert property (slot_nullify |-> in_delay_slot && instr_valid && !redirect_valid)
    else $error("bad nullify");
  a_slot_leave: assert property (in_delay_slot && instr_valid |=> !in_delay_slot) else $error("slot stuck");
endmodule
bind cbu_top cbu_top_assertions cbu_top_assertions_i (.clk_sys, .rst_n, .instr_valid, .instr, .instr_pc,
  .slot_exception, .link_we, .link_index, .link_value, .redirect_valid, .redirect_pc, .slot_nullify,
  .in_delay_slot, .restart_pc);

// *** testbench/cbu_regfile.sv ***
`timescale 1ns/100ps
module cbu_regfile (
  input wire logic clk_sys,
  input wire logic [4:0] rs_index,
  input wire logic [4:0] rt_index,
  input wire logic link_we,
  input wire logic [4:0] link_index,
  input wire logic [31:0] link_value,
  input wire logic wr_en,
  input wire logic [4:0] wr_index,
  input wire logic [31:0] wr_data,
  output logic [31:0] rs_value,
  output logic [31:0] rt_value
);
  logic [31:0] regs_q [32] = '{default: 32'h0};
  // link lands last so it wins a same-edge clash
  always @(posedge clk_sys) begin
    if (wr_en) regs_q[wr_index] <= wr_data;
    if (link_we) regs_q[link_index] <= link_value;
  end
  // zero register reads zero
  assign rs_value = (rs_index == 5'h00) ? 32'h0 : regs_q[rs_index];
  assign rt_value = (rt_index == 5'h00) ? 32'h0 : regs_q[rt_index];
endmodule

// *** testbench/test_cbu_top.sv ***
`timescale 1ns/100ps
module test_cbu_top;
  logic clk_sys = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, slot_exception = 1'b0, wr_en = 1'b0;
  logic [31:0] instr = 32'h0, instr_pc = 32'h0, wr_data = 32'h0, seed = 32'h70e5, va, vb, ea, eb, pc;
  logic [4:0] wr_index = 5'h0, a, b;
  logic [31:0] rs_value, rt_value, link_value, redirect_pc, restart_pc;
  logic [4:0] rs_index, rt_index, link_index;
  logic link_we, redirect_valid, slot_nullify, in_delay_slot, cnd, ex, gp;
  logic [15:0] off;
  logic [5:0] opc [6] = '{6'h04, 6'h14, 6'h01, 6'h01, 6'h01, 6'h01};
  logic [4:0] rtc [6] = '{5'h00, 5'h00, 5'h01, 5'h03, 5'h11, 5'h13};
  int fails = 0, samples_checked = 0, k;
  cbu_top cbu_top_i (.clk_sys, .rst_n, .instr_valid, .instr, .instr_pc, .rs_value, .rt_value, .slot_exception,
    .rs_index, .rt_index, .link_we, .link_index, .link_value, .redirect_valid, .redirect_pc, .slot_nullify,
    .in_delay_slot, .restart_pc);
  cbu_regfile cbu_regfile_i (.clk_sys, .rs_index, .rt_index, .link_we, .link_index, .link_value, .wr_en,
    .wr_index, .wr_data, .rs_value, .rt_value);
  function automatic logic [31:0] tgt(input logic [31:0] p, input logic [15:0] o);
    return p + 32'h4 + {{14{o[15]}}, o, 2'b00};
  endfunction
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // one step of the fixed-seed generator
  task automatic nxt();
    seed = xorshift(seed);
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #50 clk_sys = ~clk_sys;
  // run is about 1700 cycles; the limit leaves ample margin
  initial begin
    #2000000;
    fails++;
    print_verdict();
  end
  // ****************************************
  // random branches, zero-register aliases
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int n = 0; n < 300; n++) begin
      nxt();
      // likely forms drawn as often as plain ones, against software habit, so nullify is seen
      k = seed[15:0] % 6;
      a = (seed[27:26] == 2'h0) ? 5'h00 : seed[20:16] % 5'd31;
      b = (seed[27:26] == 2'h0) ? 5'h00 : seed[25:21] % 5'd31;
      gp = seed[28];
      nxt();
      va = seed;
      nxt();
      vb = seed[0] ? va : seed;
      off = seed[31:16];
      ex = seed[15:13] == 3'h0;
      pc = {seed[31:2] ^ va[31:2], 2'b00};
      // hand-picked corners first: every form on the zero register, extreme offsets
      if (n < 6) begin
        k = n;
        a = 5'h00;
        b = 5'h00;
        off = n[0] ? 16'h8000 : 16'h7fff;
      end
      ea = (a == 5'h00) ? 32'h0 : ((a == b) ? vb : va);
      eb = (b == 5'h00) ? 32'h0 : vb;
      cnd = (k > 1) ? !ea[31] : ea == eb;
      @(posedge clk_sys) {wr_en, wr_index, wr_data} <= {1'b1, a, va};
      @(posedge clk_sys) {wr_index, wr_data} <= {b, vb};
      @(posedge clk_sys) {wr_en, instr_valid, instr_pc, instr} <= {2'b01, pc, opc[k], a, (k < 2) ? b : rtc[k], off};
      // the slot only ever holds a no-op, never a branch, jump or return
      @(posedge clk_sys) {instr_valid, instr, slot_exception} <= {!gp, 32'h0, ex && !gp};
      #1 chk("link_we", link_we, k > 3);
      if (k > 3) chk("link_value", link_value, pc + 32'h8);
      chk("redirect_pc", redirect_pc, tgt(pc, off));
      chk("restart_pc", restart_pc, pc);
      chk("in_delay_slot", in_delay_slot, 1);
      // reset landing in a slot must drop it and clear link_we, the slot outputs and both held addresses
      if (n == 150) begin
        @(posedge clk_sys) {rst_n, instr_valid, slot_exception} <= 3'b000;
        #1 chk("rst_outputs", {link_we, redirect_valid, slot_nullify, in_delay_slot}, 0);
        chk("rst_restart_pc", restart_pc, 32'h0);
        chk("rst_redirect_pc", redirect_pc, 32'h0);
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        continue;
      end
      if (gp) @(posedge clk_sys) {instr_valid, slot_exception} <= {1'b1, ex};
      #1 chk("redirect_valid", redirect_valid, cnd && !ex);
      chk("slot_nullify", slot_nullify, (k % 2 == 1) && !cnd && !ex);
      @(posedge clk_sys) {instr_valid, slot_exception} <= 2'b00;
      #1 chk("slot_done", in_delay_slot, 0);
    end
    print_verdict();
  end
endmodule
